// File: src/trc_fifo.sv
// Shared constants of the trinary code link and the receive word FIFO
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Constants
// ****************************************************************
package trc_pkg;
  // Trinary digit codes, two bits per digit
  localparam logic [1:0] TRC_LOW = 2'h0;
  localparam logic [1:0] TRC_HIGH = 2'h1;
  localparam logic [1:0] TRC_OPEN = 2'h2;
  localparam int TRC_DIGITS = 9;
  localparam int TRC_ADDR_NIBBLE = 5;
  localparam int TRC_NIB_BITS = 4;
  localparam int TRC_CODE_SPACE = 19683;
  localparam int TRC_BIN_SPACE = 512;
  // Clock rates and the encoder clock
  localparam int TRC_CLK_PERIOD_NS = 10;
  localparam int TRC_ENC_PERIOD_NS = 10000;
  localparam int TRC_ENC_DIV = TRC_ENC_PERIOD_NS / TRC_CLK_PERIOD_NS;
  // Pulse shape in encoder clocks; one data period is two slots
  localparam int TRC_SLOT_TICKS = 4;
  localparam int TRC_SHORT_TICKS = 1;
  localparam int TRC_LONG_TICKS = 3;
  localparam int TRC_DATA_PERIOD_TICKS = 2 * TRC_SLOT_TICKS;
  localparam int TRC_WORD_GAP_PERIODS = 3;
  localparam int TRC_GAP_TICKS = TRC_WORD_GAP_PERIODS * TRC_DATA_PERIOD_TICKS;
  // Decoder thresholds, in hundredths and tenths of encoder clocks
  localparam int TRC_WIDTH_THR_X100 = 172;
  localparam int TRC_EOT_X10 = 335;
  localparam int TRC_EOW_X10 = 134;
  // Settle time of one weak drive test, in clocks
  localparam int TRC_TEST_CYC = 4;
  localparam int TRC_FIFO_DEPTH = 8;
  localparam int TRC_CW = 16;
endpackage : trc_pkg

// ****************************************************************
// FIFO
// ****************************************************************
module trc_fifo
  import trc_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = TRC_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // Drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire do_wr;
  wire do_rd;

  // Honest flags straight from the fill count
  assign o_in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_wr)
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (do_rd)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  // Storage needs no reset; valid gates every read
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      mem_q[wr_q] <= i_in_data;
  end
endmodule : trc_fifo

`default_nettype wire

// File: src/trc_link.sv
// Trinary remote code link: encoder and decoder with receive FIFO
//
// Notes on behaviour
// RULE1 - nine code inputs, each low, high or open
// RULE2 - held enable repeats; brief pulse sends one sequence
// RULE3 - first word after power-up may be invalid
// RULE4 - three idle data periods between the words
// RULE5 - low SS, high LL, open LS pulses
// RULE6 - weak drive high then low classifies input
// RULE7 - idle and enable high stops the oscillator
// RULE8 - enable low starts oscillator, samples inputs sequentially
// RULE9 - nibble decoder: first five digits are address
// RULE10 - first word match stores nibble, latch unchanged
// RULE11 - second word equal nibble loads output latch; here skipped while a push is pending
// RULE12 - valid flag until mismatch or four silent periods
// RULE13 - open data digit decodes as one
// RULE14 - address-only variant: nine digits, two matching words
// RULE15 - binary-only address digits give 512 addresses
// RULE16 - long pulse when wider than 1.72 clocks
// RULE17 - low for 33.5 encoder clocks ends transmission
// RULE18 - low for about two data periods ends word
// RULE19 - local address trinary or binary, must equal encoder
// RULE20 - pulse and period lengths are matched parameters
`timescale 1ns/100ps
`default_nettype none

module trc_link
  import trc_pkg::*;
#(
  parameter bit NIBBLE_MODE = 1'b1,
  parameter int ENC_DIV = TRC_ENC_DIV,
  parameter int WIDTH_THR_CYC = (TRC_WIDTH_THR_X100 * ENC_DIV) / 100,
  parameter int EOW_CYC = (TRC_EOW_X10 * ENC_DIV) / 10,
  parameter int EOT_CYC = (TRC_EOT_X10 * ENC_DIV) / 10,
  parameter int FIFO_DEPTH = TRC_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Encoder control
  input wire logic i_transmit_enable_n,
  output logic o_osc_running,
  // Encoder code pins, weakly driven during classification
  input wire logic [TRC_DIGITS-1:0] i_address_digit_inputs,
  output logic [TRC_DIGITS-1:0] o_address_digit_drive,
  output logic [TRC_DIGITS-1:0] o_address_digit_oe_n,
  // Encoder serial output
  output logic o_serial_out,
  // Decoder serial input and local address (two bits per digit)
  input wire logic i_serial_in,
  input wire logic [2*TRC_DIGITS-1:0] i_local_address,
  // Decoder results
  output logic o_valid_transmission,
  output logic [TRC_NIB_BITS-1:0] o_decoded_nibble_outputs,
  // Received word stream
  output logic o_rx_valid,
  output logic [2*TRC_DIGITS-1:0] o_rx_word,
  input wire logic i_rx_ready
);
  localparam int ADDR_N = NIBBLE_MODE ? TRC_ADDR_NIBBLE : TRC_DIGITS;
  localparam int WW = 2 * TRC_DIGITS;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic te_s1_q;
  logic te_s2_q;
  logic [TRC_DIGITS-1:0] pin_s1_q;
  logic [TRC_DIGITS-1:0] pin_s2_q;
  logic din_s1_q;
  logic din_s2_q;
  logic din_prev_q;
  logic [WW-1:0] loc_s1_q;
  logic [WW-1:0] loc_s2_q;

  // Every pin except i_rx_ready passes two flops before any logic sees it
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      te_s1_q <= 1'b1;
      te_s2_q <= 1'b1;
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
      din_prev_q <= 1'b0;
      loc_s1_q <= '0;
      loc_s2_q <= '0;
    end
    else
    begin
      te_s1_q <= i_transmit_enable_n;
      te_s2_q <= te_s1_q;
      pin_s1_q <= i_address_digit_inputs;
      pin_s2_q <= pin_s1_q;
      din_s1_q <= i_serial_in;
      din_s2_q <= din_s1_q;
      din_prev_q <= din_s2_q;
      loc_s1_q <= i_local_address;
      loc_s2_q <= loc_s1_q;
    end
  end

  // ****************************************************************
  // Encoder
  // ****************************************************************
  typedef enum logic [2:0] {E_IDLE, E_TEST_HI, E_TEST_LO, E_SEND, E_GAP} trc_enc_t;
  trc_enc_t est_q;
  trc_enc_t est_d;
  logic [TRC_CW-1:0] div_q;
  logic [7:0] tmr_q;
  logic [3:0] dig_q;
  logic word_q;
  logic pulse_q;
  logic [2:0] slot_q;
  logic hi_seen_q;
  logic [1:0] sym_q;
  logic dout_q;
  logic [TRC_DIGITS-1:0] drv_q;
  logic [TRC_DIGITS-1:0] oe_n_q;

  // Oscillator tick; the divider only runs while a sequence is active
  wire enc_tick = (div_q == TRC_CW'(ENC_DIV - 1)); // RULE7
  // Tests count system clocks; a held divider keeps the first slot whole
  wire div_hold = (est_q == E_IDLE) || (est_q == E_TEST_HI) || (est_q == E_TEST_LO);
  wire test_done = (tmr_q == 8'(TRC_TEST_CYC - 1));
  wire gap_done = enc_tick && (tmr_q == 8'(TRC_GAP_TICKS - 1)); // RULE4
  wire pin_now = pin_s2_q[dig_q];
  wire slot_end = enc_tick && (slot_q == 3'(TRC_SLOT_TICKS - 1));
  wire last_digit = (dig_q == 4'(TRC_DIGITS - 1));
  // Digit index after this edge, so the weak drive never lands on the old pin
  wire [3:0] dig_next = (est_q == E_SEND && slot_end && pulse_q) ?
                        (last_digit ? 4'h0 : dig_q + 4'h1) : dig_q;
  // Pulse 0 is long for high and open, pulse 1 is long only for high
  wire pulse_long = pulse_q ? (sym_q == TRC_HIGH) : (sym_q != TRC_LOW); // RULE5
  wire [2:0] pulse_len = pulse_long ? 3'(TRC_LONG_TICKS) : 3'(TRC_SHORT_TICKS); // RULE20
  // Both tests forced means open; otherwise the pin is hard wired
  wire [1:0] sym_dec = (hi_seen_q && !pin_now) ? TRC_OPEN :
                       (pin_now ? TRC_HIGH : TRC_LOW); // RULE6 RULE1

  // Sequence steps: test each digit, send its two pulses, gap, repeat
  always_comb
  begin
    est_d = est_q;
    case (est_q)
      E_IDLE:
        if (!te_s2_q)
          est_d = E_TEST_HI; // RULE8
      E_TEST_HI:
        if (test_done)
          est_d = E_TEST_LO;
      E_TEST_LO:
        if (test_done)
          est_d = E_SEND;
      E_SEND:
        if (slot_end && pulse_q)
          est_d = last_digit ? E_GAP : E_TEST_HI;
      E_GAP:
        if (gap_done)
          est_d = (!word_q || !te_s2_q) ? E_TEST_HI : E_IDLE; // RULE2 RULE7
      default:
        est_d = E_IDLE;
    endcase
  end

  // State, divider and test timer
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      est_q <= E_IDLE;
      div_q <= '0;
      tmr_q <= '0;
    end
    else
    begin
      est_q <= est_d;
      div_q <= (div_hold || enc_tick) ? '0 : div_q + 1'b1;
      if (est_d != est_q)
        tmr_q <= '0;
      else if (est_q == E_TEST_HI || est_q == E_TEST_LO || (est_q == E_GAP && enc_tick))
        tmr_q <= tmr_q + 1'b1;
    end
  end

  // Digit, word and pulse position; a second word always follows the first
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dig_q <= '0;
      word_q <= 1'b0;
      pulse_q <= 1'b0;
      slot_q <= '0;
      hi_seen_q <= 1'b0;
      sym_q <= TRC_LOW;
    end
    else
    begin
      if (est_q == E_TEST_HI && test_done)
        hi_seen_q <= pin_now;
      if (est_q == E_TEST_LO && test_done)
        sym_q <= sym_dec; // RULE6
      if (est_q == E_SEND && enc_tick)
        slot_q <= slot_end ? '0 : slot_q + 1'b1;
      if (est_q == E_SEND && slot_end)
      begin
        pulse_q <= !pulse_q;
        if (pulse_q)
          dig_q <= last_digit ? '0 : dig_q + 1'b1; // RULE8
      end
      if (gap_done)
        word_q <= !word_q; // RULE2
      if (est_q == E_IDLE)
      begin
        dig_q <= '0;
        word_q <= 1'b0;
        pulse_q <= 1'b0;
        slot_q <= '0;
      end
    end
  end

  // Pin drivers and serial output; output idles low in gaps and tests
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      dout_q <= 1'b0;
      drv_q <= '0;
      oe_n_q <= '1;
    end
    else
    begin
      dout_q <= (est_q == E_SEND) && (slot_q < pulse_len); // RULE5
      for (int i = 0; i < TRC_DIGITS; i++)
      begin
        drv_q[i] <= (est_d == E_TEST_HI) && (dig_next == 4'(i)); // RULE6
        oe_n_q[i] <= !(((est_d == E_TEST_HI) || (est_d == E_TEST_LO)) && (dig_next == 4'(i)));
      end
    end
  end

  assign o_serial_out = dout_q;
  assign o_address_digit_drive = drv_q;
  assign o_address_digit_oe_n = oe_n_q;
  assign o_osc_running = (est_q != E_IDLE);

  // ****************************************************************
  // Decoder pulse timing
  // ****************************************************************
  logic [TRC_CW-1:0] wid_q;
  logic [TRC_CW-1:0] low_q;
  logic half_q;
  logic first_long_q;
  logic bad_q;
  logic [3:0] rcnt_q;
  logic [WW-1:0] rx_q;

  wire din_fall = din_prev_q && !din_s2_q;
  wire rx_long = (wid_q > TRC_CW'(WIDTH_THR_CYC)); // RULE16
  wire eow = (low_q == TRC_CW'(EOW_CYC)); // RULE18
  wire eot = (low_q == TRC_CW'(EOT_CYC)); // RULE17
  // Pulse pair to digit; short then long is no legal digit
  wire [1:0] rx_digit = first_long_q ? (rx_long ? TRC_HIGH : TRC_OPEN) : TRC_LOW; // RULE5
  wire pair_bad = !first_long_q && rx_long;

  // High width and low time counters, both saturating
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wid_q <= '0;
      low_q <= '0;
    end
    else
    begin
      if (din_s2_q)
        wid_q <= (wid_q == '1) ? wid_q : wid_q + 1'b1;
      else if (!din_prev_q)
        wid_q <= '0;
      if (din_s2_q)
        low_q <= '0;
      else if (low_q != TRC_CW'(EOT_CYC))
        low_q <= low_q + 1'b1;
    end
  end

  // Assemble digits of one word; end of word clears the assembly
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      half_q <= 1'b0;
      first_long_q <= 1'b0;
      bad_q <= 1'b0;
      rcnt_q <= '0;
      rx_q <= '0;
    end
    else if (eow || eot)
    begin
      half_q <= 1'b0;
      bad_q <= 1'b0;
      rcnt_q <= '0;
    end
    else if (din_fall)
    begin
      half_q <= !half_q;
      if (!half_q)
        first_long_q <= rx_long;
      else if (rcnt_q == 4'(TRC_DIGITS))
        bad_q <= 1'b1;
      else
      begin
        rx_q[2*rcnt_q +: 2] <= rx_digit;
        rcnt_q <= rcnt_q + 1'b1;
        if (pair_bad)
          bad_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Decoder word checks
  // ****************************************************************
  logic [TRC_DIGITS-1:0] match_w;
  logic [TRC_NIB_BITS-1:0] nib_w;

  // Per digit address compare on the trinary codes
  genvar g;
  generate
    for (g = 0; g < TRC_DIGITS; g++)
    begin : g_dig
      assign match_w[g] = (g >= ADDR_N) || (rx_q[2*g +: 2] == loc_s2_q[2*g +: 2]); // RULE9 RULE14 RULE19 RULE15
      if (g >= TRC_ADDR_NIBBLE)
      begin : g_nib
        assign nib_w[g - TRC_ADDR_NIBBLE] = (rx_q[2*g +: 2] != TRC_LOW); // RULE13
      end
    end
  endgenerate

  logic widx_q;
  logic first_ok_q;
  logic [TRC_NIB_BITS-1:0] stored_q;
  logic [TRC_NIB_BITS-1:0] nib_out_q;
  logic vt_q;
  logic pend_q;
  logic [WW-1:0] pend_word_q;
  logic fifo_ready;

  wire word_good = eow && !bad_q && !half_q && (rcnt_q == 4'(TRC_DIGITS)) && (&match_w);
  // Address-only words are compared in full through the address itself
  wire nib_same = !NIBBLE_MODE || (nib_w == stored_q); // RULE11 RULE14
  wire pair_ok = widx_q && word_good && first_ok_q && nib_same;
  // A pending push stalls acceptance of the next pair
  wire pair_take = pair_ok && !pend_q;

  // Two words per sequence; the second must repeat the first
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      widx_q <= 1'b0;
      first_ok_q <= 1'b0;
      stored_q <= '0;
      nib_out_q <= '0;
      vt_q <= 1'b0;
    end
    else if (eot)
    begin
      widx_q <= 1'b0;
      first_ok_q <= 1'b0;
      vt_q <= 1'b0; // RULE12 RULE17
    end
    else if (eow)
    begin
      widx_q <= !widx_q;
      if (!widx_q)
      begin
        first_ok_q <= word_good; // RULE10
        if (word_good)
          stored_q <= nib_w; // RULE10
        else
          vt_q <= 1'b0; // RULE12
      end
      else
      begin
        first_ok_q <= 1'b0;
        if (pair_take)
        begin
          nib_out_q <= nib_w; // RULE11
          vt_q <= 1'b1; // RULE12 RULE14
        end
        else if (!pair_ok)
          vt_q <= 1'b0; // RULE12
      end
    end
  end

  // Hold the accepted word until the FIFO takes it
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pend_q <= 1'b0;
      pend_word_q <= '0;
    end
    else if (eow && pair_take)
    begin
      pend_q <= 1'b1;
      pend_word_q <= rx_q;
    end
    else if (fifo_ready)
      pend_q <= 1'b0;
  end

  trc_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_in_valid(pend_q),
    .i_in_data(pend_word_q),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_word),
    .i_out_ready(i_rx_ready)
  );

  assign o_valid_transmission = vt_q;
  assign o_decoded_nibble_outputs = NIBBLE_MODE ? nib_out_q : '0;
endmodule : trc_link

`default_nettype wire

// File: tb/trc_pins.sv
// Trinary switch bank model on the encoder code pins
`timescale 1ns/100ps
`default_nettype none

// ****
// Switch bank
// ****
module trc_pins
  import trc_pkg::*;
(
  // Clock and switch settings
  input wire logic i_clk,
  input wire logic [2*TRC_DIGITS-1:0] i_set,
  // Weak drive from the encoder
  input wire logic [TRC_DIGITS-1:0] i_drv,
  input wire logic [TRC_DIGITS-1:0] i_oe_n,
  // Resolved pin levels
  output logic [TRC_DIGITS-1:0] o_pin
);
  logic tgl_q = 1'h0;

  // Undriven open pins wander, so a stale level is never trusted
  always_ff @(posedge i_clk)
    tgl_q <= ~tgl_q;

  // Strapped pins win over the weak drive; open pins follow it
  always_comb
  begin
    for (int i = 0; i < TRC_DIGITS; i++)
    begin
      if (i_set[2*i+:2] == TRC_LOW)
        o_pin[i] = 1'h0;
      else if (i_set[2*i+:2] == TRC_HIGH)
        o_pin[i] = 1'h1;
      else
        o_pin[i] = i_oe_n[i] ? tgl_q : i_drv[i];
    end
  end
endmodule : trc_pins
`default_nettype wire

// File: tb/trc_link_chk.sv
// Concurrent checks on the trinary link top ports
`timescale 1ns/100ps
`default_nettype none

// ****
// Checker
// ****
module trc_link_chk
  import trc_pkg::*;
#(
  parameter int ENC_DIV = TRC_ENC_DIV,
  parameter int EOW_CYC = (TRC_EOW_X10 * ENC_DIV) / 10,
  parameter int EOT_CYC = (TRC_EOT_X10 * ENC_DIV) / 10
)
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Encoder side
  input wire logic i_transmit_enable_n,
  input wire logic o_osc_running,
  input wire logic [TRC_DIGITS-1:0] o_address_digit_drive,
  input wire logic [TRC_DIGITS-1:0] o_address_digit_oe_n,
  input wire logic o_serial_out,
  // Decoder side
  input wire logic i_serial_in,
  input wire logic o_valid_transmission,
  input wire logic [TRC_NIB_BITS-1:0] o_decoded_nibble_outputs,
  input wire logic o_rx_valid
);
  localparam int SH = TRC_SHORT_TICKS * ENC_DIV;
  localparam int LG = TRC_LONG_TICKS * ENC_DIV;
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [15:0] sil_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Run lengths; the low ones saturate so long idles never wrap
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hi_q <= 16'h0;
      lo_q <= 16'h0;
      sil_q <= 16'h0;
    end
    else
    begin
      hi_q <= o_serial_out ? hi_q + 16'h1 : 16'h0;
      lo_q <= o_serial_out ? 16'h0 : lo_q + {15'h0, ~&lo_q};
      sil_q <= i_serial_in ? 16'h0 : sil_q + {15'h0, ~&sil_q};
    end
  end

  // First weak test of a sequence drives digit 0 high
  sequence first_hi;
    !o_address_digit_oe_n[0] && o_address_digit_drive[0];
  endsequence
  sequence vt_up;
    $rose(o_valid_transmission);
  endsequence

  one_test_a: assert property ($onehot0(~o_address_digit_oe_n))
    else $error("more than one code pin under test");
  weak_drv_a: assert property ((o_address_digit_drive & o_address_digit_oe_n) == 9'h0)
    else $error("drive value on an undriven pin");
  osc_gate_a: assert property (o_serial_out |-> o_osc_running)
    else $error("serial pulse while oscillator idle");
  pulse_len_a: assert property ($fell(o_serial_out) |-> hi_q == SH || hi_q == LG)
    else $error("serial pulse width wrong");
  word_gap_a: assert property ($rose(o_serial_out) && lo_q > 5 * ENC_DIV
    |-> lo_q >= TRC_GAP_TICKS * ENC_DIV)
    else $error("word gap too short");
  osc_start_a: assert property ($rose(o_osc_running) |-> !$past(i_transmit_enable_n, 2))
    else $error("oscillator started without enable");
  test_first_a: assert property ($rose(o_osc_running) |-> ##[0:1] first_hi)
    else $error("sequence did not open with high test");
  vt_eot_a: assert property (sil_q == EOT_CYC + 8 |-> !o_valid_transmission)
    else $error("valid flag outlived silence");
  vt_eow_a: assert property (vt_up |-> sil_q >= EOW_CYC && sil_q <= EOW_CYC + 8)
    else $error("valid flag off the word end");
  push_a: assert property (vt_up |-> ##[0:3] o_rx_valid)
    else $error("valid pair not queued");
  nib_hold_a: assert property ($changed(o_decoded_nibble_outputs) |-> o_valid_transmission)
    else $error("nibble changed without valid pair");
endmodule : trc_link_chk

bind trc_link trc_link_chk #(.ENC_DIV(ENC_DIV), .EOW_CYC(EOW_CYC), .EOT_CYC(EOT_CYC)) u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_transmit_enable_n(i_transmit_enable_n),
  .o_osc_running(o_osc_running), .o_address_digit_drive(o_address_digit_drive),
  .o_address_digit_oe_n(o_address_digit_oe_n), .o_serial_out(o_serial_out),
  .i_serial_in(i_serial_in), .o_valid_transmission(o_valid_transmission),
  .o_decoded_nibble_outputs(o_decoded_nibble_outputs), .o_rx_valid(o_rx_valid));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the trinary link in loopback
`timescale 1ns/100ps
`default_nettype none

// ****
// Bench
// ****
module tb;
  import trc_pkg::*;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic te_n = 1'h1;
  logic rdy = 1'h0;
  logic [17:0] set = 18'h0;
  logic [17:0] loc = 18'h0;
  logic [17:0] code;
  logic [17:0] rxw;
  logic [8:0] pin;
  logic [8:0] drv;
  logic [8:0] oe_n;
  logic [3:0] nib;
  logic [3:0] last_nib = 4'h0;
  logic [15:0] lfsr = 16'h004B;
  logic so;
  logic vt;
  logic vt9;
  logic osc;
  logic rxv;
  int num_errors = 0;
  int n_compared = 0;

  // Short encoder clock keeps each sequence near 1700 cycles
  trc_link #(.ENC_DIV(8)) u_dut (
    .i_clk(clk), .i_arst_n(arst_n), .i_transmit_enable_n(te_n), .o_osc_running(osc),
    .i_address_digit_inputs(pin), .o_address_digit_drive(drv),
    .o_address_digit_oe_n(oe_n), .o_serial_out(so), .i_serial_in(so),
    .i_local_address(loc), .o_valid_transmission(vt), .o_decoded_nibble_outputs(nib),
    .o_rx_valid(rxv), .o_rx_word(rxw), .i_rx_ready(rdy));

  // Address-only variant listens on the same line and pops with the same ready
  trc_link #(.NIBBLE_MODE(1'b0), .ENC_DIV(8)) u_dut_addr (
    .i_clk(clk), .i_arst_n(arst_n), .i_transmit_enable_n(te_n), .o_osc_running(),
    .i_address_digit_inputs(pin), .o_address_digit_drive(), .o_address_digit_oe_n(),
    .o_serial_out(), .i_serial_in(so), .i_local_address(loc), .o_valid_transmission(vt9),
    .o_decoded_nibble_outputs(), .o_rx_valid(), .o_rx_word(), .i_rx_ready(rdy));

  trc_pins u_pins (.i_clk(clk), .i_set(set), .i_drv(drv), .i_oe_n(oe_n), .o_pin(pin));

  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  // Data digits: high and open both read as one
  function automatic logic [3:0] exp_nib(input logic [17:0] c);
    for (int i = 0; i < 4; i++)
      exp_nib[i] = c[2*(5+i)+:2] != TRC_LOW;
  endfunction : exp_nib

  // Address digit 0 turned to another state
  function automatic logic [17:0] miss(input logic [17:0] c);
    return {c[17:2], c[1:0] == TRC_LOW ? TRC_HIGH : TRC_LOW};
  endfunction : miss

  task automatic chk(input string what, input logic [17:0] e, input logic [17:0] g);
    n_compared++;
    if (e !== g)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // Random trinary code from the shift register
  task automatic rnd(output logic [17:0] c);
    for (int i = 0; i < 9; i++)
    begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      c[2*i+:2] = lfsr[1:0] == 2'h3 ? TRC_OPEN : lfsr[1:0];
    end
  endtask : rnd

  // Bounded wait for the encoder to go quiet
  task automatic wait_idle();
    int k;
    k = 0;
    while (osc === 1'h1 && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    #1;
    chk("osc_stop", 18'h0, {17'h0, osc});
  endtask : wait_idle

  // One brief enable pulse and its single two-word sequence
  task automatic round(input logic [17:0] c, input logic [17:0] la, input logic e_vt);
    set <= c;
    loc <= la;
    @(posedge clk) te_n <= 1'h0;
    repeat (3) @(posedge clk);
    te_n <= 1'h1;
    repeat (5) @(posedge clk);
    chk("osc_run", 18'h1, {17'h0, osc});
    wait_idle();
    if (e_vt)
      last_nib = exp_nib(c);
    chk("vt", {17'h0, e_vt}, {17'h0, vt});
    chk("vt9", {17'h0, e_vt}, {17'h0, vt9});
    chk("nib", {14'h0, last_nib}, {14'h0, nib});
    chk("rx_v", {17'h0, e_vt}, {17'h0, rxv});
    if (e_vt)
      chk("rx_w", c, rxw);
    @(posedge clk) rdy <= 1'h1;
    @(posedge clk) rdy <= 1'h0;
    repeat (300) @(posedge clk);
    chk("rx_one", 18'h0, {17'h0, rxv});
    chk("vt_eot", 18'h0, {17'h0, vt});
    chk("osc_off", 18'h0, {17'h0, osc});
    $display("round %h done", c);
  endtask : round

  // Held enable repeats until the queue refuses, then drain it
  task automatic fill(input logic [17:0] c);
    int k;
    set <= c;
    loc <= c;
    @(posedge clk) te_n <= 1'h0;
    repeat (17000) @(posedge clk);
    te_n <= 1'h1;
    wait_idle();
    chk("vt_held", 18'h1, {17'h0, vt});
    chk("vt9_held", 18'h1, {17'h0, vt9});
    @(posedge clk) rdy <= 1'h1;
    k = 0;
    #1;
    while (rxv === 1'h1 && k < 20)
    begin
      chk("fifo_w", c, rxw);
      k++;
      @(posedge clk);
      #1;
    end
    rdy <= 1'h0;
    // A full queue leaves one more word waiting in the push stage
    chk("fifo_n", 18'(TRC_FIFO_DEPTH + 1), k[17:0]);
    $display("fill done, %0d words", k);
  endtask : fill

  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // Main sequence; the first round after reset sends to a mismatched local address and expects no valid flag
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'h1;
    round(18'h0, miss(18'h0), 1'h0);
    round(18'h0, 18'h0, 1'h1);
    round(18'h15555, 18'h15555, 1'h1);
    round(18'h2AAAA, 18'h2AAAA, 1'h1);
    for (int r = 0; r < 4; r++)
    begin
      rnd(code);
      round(code, code, 1'h1);
      round(code, miss(code), 1'h0);
    end
    fill(code);
    final_report();
  end

  // Watchdog well beyond the expected 42k cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report();
  end
endmodule : tb
`default_nettype wire
